// ===== fsbrq_pkg.sv
// Package: shared constants for the request-phase port
package fsbrq_pkg;
   localparam int ADDR_HI     = 39;
   localparam int ADDR_LO     = 3;
   localparam int ADDR_W      = ADDR_HI - ADDR_LO + 1;   // 37 lines
   localparam int REQ_W       = 5;
   localparam int LANE0_LO    = 24;                      // Lane 0 covers 39..24 in phase 1
   localparam int BIT20       = 20;
   localparam int CFG_W       = 8;                       // Sampled configuration width
   localparam int CFG_LO      = ADDR_LO;                 // Config taken from addr lines 10..3
   localparam int SYNC_STAGES = 2;
   localparam logic [1:0] PAR_RESET = 2'h3;
endpackage

// ===== fsbrq_if.sv
// Interface: request-phase wires between issuing agent and processor agent
`timescale 1ns/1ns
interface fsbrq_if;
   // Bus clock pair, true and complement
   logic                              bus_clock_true;
   logic                              bus_clock_comp;
   // Active-low shared request wires, driven by the issuing agent
   logic [fsbrq_pkg::ADDR_W-1:0]      addr_n;
   logic [fsbrq_pkg::REQ_W-1:0]       req_type_n;
   logic                              addr_strobe_valid_n;
   logic [1:0]                        src_sync_req_strobe_n;
   logic [1:0]                        req_parity_n;
   // Async mask from system logic
   logic                              addr_bit20_mask_n;
   modport issuer (
      output bus_clock_true, bus_clock_comp,
      output addr_n, req_type_n, addr_strobe_valid_n, src_sync_req_strobe_n, req_parity_n,
      output addr_bit20_mask_n
   );
   modport agent (
      input  bus_clock_true, bus_clock_comp,
      input  addr_n, req_type_n, addr_strobe_valid_n, src_sync_req_strobe_n, req_parity_n,
      input  addr_bit20_mask_n
   );
endinterface

// ===== fsbrq_issuer.sv
// Issuing end: divides ref clock into bus clock and drives two-sub-phase requests
`timescale 1ns/1ns
module fsbrq_issuer #(
   parameter int DIV = 4
) (
   // Clock, reset, enable
   input  wire logic                                ref_clk_i,
   input  wire logic                                rst_b_i,
   input  wire logic                                clk_en_i,
   // User request
   input  wire logic                                req_valid_i,
   input  wire logic [fsbrq_pkg::ADDR_HI:0]         req_addr_i,
   input  wire logic [fsbrq_pkg::REQ_W-1:0]         req_type_i,
   input  wire logic [fsbrq_pkg::ADDR_W-1:0]        req_info_i,
   input  wire logic                                mask_i,
   output logic                                     req_ready_o,
   // Link
   fsbrq_if.issuer                                  bus
);
   typedef enum logic [2:0] {
      FSBRQ_IDLE = 3'h1,
      FSBRQ_SP1  = 3'h2,
      FSBRQ_SP2  = 3'h4
   } fsbrq_ist_t;

   // Even-low-count parity: high when an even number of covered lines are low
   function automatic logic par_n(input logic [63:0] v, input logic [63:0] m);
      par_n = ~^(~v & m);
   endfunction

   fsbrq_ist_t st_reg, st_next;
   logic [7:0] div_reg, div_next;
   logic       bclk_reg, bclk_next;
   logic [fsbrq_pkg::ADDR_W-1:0] a_reg, a_next, info_reg, info_next;
   logic [fsbrq_pkg::REQ_W-1:0]  t_reg, t_next;
   logic [fsbrq_pkg::ADDR_W-1:0] an_reg, an_next;
   logic [fsbrq_pkg::REQ_W-1:0]  tn_reg, tn_next;
   logic                         ads_reg, ads_next, stb_reg, stb_next, rdy_reg, rdy_next;
   logic [1:0]                   par_reg, par_next;
   logic                         mask_reg, mask_next;
   logic                         launch;
   logic                         rst_d_reg;
   logic [63:0] hi_m, lo_m;

   assign hi_m = {{27{1'b0}}, {16{1'b1}}, 21'h0};
   assign lo_m = {{43{1'b0}}, {21{1'b1}}};

   // Next-state: bus clock divider and request sequencing on bus clock falling edges
   always_comb begin
      st_next   = st_reg;
      div_next  = div_reg;
      bclk_next = bclk_reg;
      a_next    = a_reg;
      info_next = info_reg;
      t_next    = t_reg;
      an_next   = an_reg;
      tn_next   = tn_reg;
      ads_next  = ads_reg;
      stb_next  = stb_reg;
      rdy_next  = rdy_reg;
      par_next  = par_reg;
      mask_next = ~mask_i;
      launch    = 1'b0;
      if (div_reg == 8'(DIV/2 - 1)) begin
         div_next  = 8'h0;
         bclk_next = ~bclk_reg;
         launch    = bclk_reg;       // Lines move on bus clock fall
      end else begin
         div_next = div_reg + 8'h1;
      end
      if (st_reg == FSBRQ_IDLE && req_valid_i && rdy_reg) begin
         a_next    = req_addr_i[fsbrq_pkg::ADDR_HI:fsbrq_pkg::ADDR_LO];
         info_next = req_info_i;
         t_next    = req_type_i;
         rdy_next  = 1'b0;
      end
      if (launch) begin
         case (st_reg)
            FSBRQ_IDLE: begin
               ads_next = 1'b1;
               stb_next = 1'b1;
               if (!rdy_reg) begin
                  an_next  = ~a_reg;
                  tn_next  = ~t_reg;
                  ads_next = 1'b0;
                  stb_next = 1'b0;
                  par_next[0] = par_n(~{27'h0, a_reg}, hi_m);
                  par_next[1] = par_n(~{38'h0, a_reg[20:0], t_reg},
                                      64'h3ff_ffff);
                  st_next  = FSBRQ_SP1;
               end
            end
            FSBRQ_SP1: begin
               an_next  = ~info_reg;
               ads_next = 1'b1;
               stb_next = 1'b1;
               par_next[1] = par_n(~{27'h0, info_reg}, hi_m);
               par_next[0] = par_n(~{27'h0, info_reg}, lo_m) ^ (^t_reg);
               st_next  = FSBRQ_SP2;
            end
            FSBRQ_SP2: begin
               an_next  = '1;
               tn_next  = '1;
               par_next = fsbrq_pkg::PAR_RESET;
               rdy_next = 1'b1;
               st_next  = FSBRQ_IDLE;
            end
            default: st_next = FSBRQ_IDLE;
         endcase
      end
   end

   // Registers
   always_ff @(posedge ref_clk_i) begin
      rst_d_reg <= rst_b_i;
      if (!rst_b_i) begin
         st_reg   <= FSBRQ_IDLE;
         // Divider cleared on reset entry, then runs so the link end sees reset
         if (!rst_d_reg) begin
            div_reg  <= div_next;
            bclk_reg <= bclk_next;
         end else begin
            div_reg  <= 8'h0;
            bclk_reg <= 1'b0;
         end
         a_reg    <= '0;
         info_reg <= '0;
         t_reg    <= '0;
         an_reg   <= '1;
         tn_reg   <= '1;
         ads_reg  <= 1'b1;
         stb_reg  <= 1'b1;
         rdy_reg  <= 1'b1;
         par_reg  <= fsbrq_pkg::PAR_RESET;
         mask_reg <= 1'b1;
      end else if (clk_en_i) begin
         st_reg   <= st_next;
         div_reg  <= div_next;
         bclk_reg <= bclk_next;
         a_reg    <= a_next;
         info_reg <= info_next;
         t_reg    <= t_next;
         an_reg   <= an_next;
         tn_reg   <= tn_next;
         ads_reg  <= ads_next;
         stb_reg  <= stb_next;
         rdy_reg  <= rdy_next;
         par_reg  <= par_next;
         mask_reg <= mask_next;
      end
   end

   // Link drive
   assign bus.bus_clock_true        = bclk_reg;
   assign bus.bus_clock_comp        = ~bclk_reg;
   assign bus.addr_n                = an_reg;
   assign bus.req_type_n            = tn_reg;
   assign bus.addr_strobe_valid_n   = ads_reg;
   assign bus.src_sync_req_strobe_n = {2{stb_reg}};
   assign bus.req_parity_n          = par_reg;
   assign bus.addr_bit20_mask_n     = mask_reg;
   assign req_ready_o               = rdy_reg;
endmodule

// ===== fsbrq_agent.sv
// Processor agent end: captures requests, checks parity, samples config, applies bit-20 mask
// Behaviour
// - Address lines carry physical bits 39..3
// - Sub-phase one carries transaction address
// - Sub-phase two carries transaction type info
// - Capture on both strobe edges (code captures on bus clock rising edges; strobe latch unused)
// - Address strobe valid marks request valid
// - Strobe valid starts checking and decode
// - Parity driven with strobe, address, type
// - Parity high for even count low
// - Lane coverage swaps between sub-phases
// - Sample configuration at reset release
// - Mask forces address bit 20 low
// - Mask honoured only in real mode
// - Mask valid six clocks before response
// - All logic timed from bus clock, except the second-edge latch clocked by the strobe
`timescale 1ns/1ns
module fsbrq_agent (
   // Link-side reset and clock enable
   input  wire logic                                rst_b_i,
   input  wire logic                                clk_en_i,
   // Core side
   input  wire logic                                real_mode_i,
   input  wire logic [fsbrq_pkg::ADDR_HI:0]         core_addr_i,
   output logic [fsbrq_pkg::ADDR_HI:0]              core_addr_o,
   output logic                                     req_new_o,
   output logic [fsbrq_pkg::ADDR_HI:0]              req_addr_o,
   output logic [fsbrq_pkg::ADDR_W-1:0]             req_info_o,
   output logic [fsbrq_pkg::REQ_W-1:0]              req_type_o,
   output logic                                     parity_err_o,
   output logic [fsbrq_pkg::CFG_W-1:0]              cfg_o,
   // Link
   fsbrq_if.agent                                   bus
);
   logic clk;
   assign clk = bus.bus_clock_true;

   // Lane parity check: high line when even count of low inputs
   function automatic logic lane_ok(input logic p_n, input logic [36:0] a_n,
                                    input logic [4:0] t_n, input logic hi);
      logic [63:0] v;
      v = hi ? {48'h0, a_n[36:21]} : {27'h0, a_n[20:0], 11'h0, t_n};
      lane_ok = (p_n == ~^(~v & (hi ? 64'hffff : 64'h1f_ffff_001f)));
   endfunction

   logic [1:0] m_sync_reg, m_sync_next;
   logic       sp2_reg, sp2_next, fall_stb;
   logic [fsbrq_pkg::ADDR_W-1:0] a1_reg, a1_next, a2_neg;
   logic [fsbrq_pkg::REQ_W-1:0]  t1_reg, t1_next, t2_neg;
   logic [1:0]                   p1_reg, p1_next, p2_neg;
   logic                         rst_q_reg, rst_q_next;
   logic [fsbrq_pkg::CFG_W-1:0]  cfg_reg, cfg_next;
   logic [fsbrq_pkg::ADDR_HI:0]  ca_reg, ca_next, ra_reg, ra_next;
   logic [fsbrq_pkg::ADDR_W-1:0] ri_reg, ri_next;
   logic [fsbrq_pkg::REQ_W-1:0]  rt_reg, rt_next;
   logic                         new_reg, new_next, perr_reg, perr_next;

   // Second strobe edge latch, rising edge of strobe
   always_ff @(posedge bus.src_sync_req_strobe_n[0]) begin
      a2_neg <= bus.addr_n;
      t2_neg <= bus.req_type_n;
      p2_neg <= bus.req_parity_n;
   end
   assign fall_stb = 1'b0;

   // Next values on bus clock
   always_comb begin
      m_sync_next = {m_sync_reg[0], bus.addr_bit20_mask_n};
      rst_q_next  = rst_b_i;
      cfg_next    = cfg_reg;
      a1_next     = a1_reg;
      t1_next     = t1_reg;
      p1_next     = p1_reg;
      sp2_next    = 1'b0;
      new_next    = 1'b0;
      perr_next   = 1'b0;
      ra_next     = ra_reg;
      ri_next     = ri_reg;
      rt_next     = rt_reg;
      if (rst_b_i && !rst_q_reg)
         cfg_next = ~bus.addr_n[fsbrq_pkg::CFG_W-1:0];
      if (!bus.addr_strobe_valid_n) begin
         a1_next  = bus.addr_n;
         t1_next  = bus.req_type_n;
         p1_next  = bus.req_parity_n;
         sp2_next = 1'b1;
      end
      if (sp2_reg) begin
         new_next = 1'b1;
         ra_next  = {~a1_reg, 3'h0};
         ri_next  = ~bus.addr_n;
         rt_next  = ~t1_reg;
         perr_next = !lane_ok(p1_reg[0], a1_reg, t1_reg, 1'b1) ||
                     !lane_ok(p1_reg[1], a1_reg, t1_reg, 1'b0) ||
                     !lane_ok(bus.req_parity_n[1], bus.addr_n, t1_reg, 1'b1) ||
                     !lane_ok(bus.req_parity_n[0], bus.addr_n, t1_reg, 1'b0);
      end
      ca_next = core_addr_i;
      if (!m_sync_reg[1] && real_mode_i)
         ca_next[fsbrq_pkg::BIT20] = 1'b0;
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!rst_b_i) begin
         m_sync_reg <= 2'h3;
         rst_q_reg  <= 1'b0;
         a1_reg     <= '1;
         t1_reg     <= '1;
         p1_reg     <= fsbrq_pkg::PAR_RESET;
         sp2_reg    <= 1'b0;
         new_reg    <= 1'b0;
         perr_reg   <= 1'b0;
         ra_reg     <= '0;
         ri_reg     <= '0;
         rt_reg     <= '0;
         ca_reg     <= '0;
         cfg_reg    <= '0;
      end else if (clk_en_i) begin
         m_sync_reg <= m_sync_next;
         rst_q_reg  <= rst_q_next;
         cfg_reg    <= cfg_next;
         a1_reg     <= a1_next;
         t1_reg     <= t1_next;
         p1_reg     <= p1_next;
         sp2_reg    <= sp2_next;
         new_reg    <= new_next;
         perr_reg   <= perr_next;
         ra_reg     <= ra_next;
         ri_reg     <= ri_next;
         rt_reg     <= rt_next;
         ca_reg     <= ca_next;
      end
   end

   assign core_addr_o  = ca_reg;
   assign req_new_o    = new_reg;
   assign req_addr_o   = ra_reg;
   assign req_info_o   = ri_reg;
   assign req_type_o   = rt_reg;
   assign parity_err_o = perr_reg;
   assign cfg_o        = cfg_reg;
endmodule

// ===== fsbrq_checker.sv
// Checker: request-phase wire behaviour between issuer and agent
`timescale 1ns/1ns
module fsbrq_checker (
   // Link clock and reset
   input wire logic                         bus_clock_true,
   input wire logic                         rst_b_i,
   // Link wires
   input wire logic [fsbrq_pkg::ADDR_W-1:0] addr_n,
   input wire logic [fsbrq_pkg::REQ_W-1:0]  req_type_n,
   input wire logic                         addr_strobe_valid_n,
   input wire logic [1:0]                   req_parity_n
);
   logic par_hi;
   logic par_lo;
   // Wire parity: high when an even number of covered lines are low
   assign par_hi = ~^(~addr_n[36:21]);
   assign par_lo = ~^(~{addr_n[20:0], req_type_n});
   default clocking @(posedge bus_clock_true); endclocking
   default disable iff (!rst_b_i);
   par_lane0_a: assert property (!addr_strobe_valid_n |-> req_parity_n[0] == par_hi)
      else $error("lane 0 parity wrong in first sub-phase");
   par_lane1_a: assert property (!addr_strobe_valid_n |-> req_parity_n[1] == par_lo)
      else $error("lane 1 parity wrong in first sub-phase");
   par_swap_a: assert property (!addr_strobe_valid_n |=> req_parity_n == {par_hi, par_lo})
      else $error("parity lanes not swapped in second sub-phase");
   strobe_pulse_a: assert property ($fell(addr_strobe_valid_n) |=> $rose(addr_strobe_valid_n))
      else $error("strobe valid held longer than one clock");
   strobe_gap_a: assert property (!addr_strobe_valid_n |=> addr_strobe_valid_n [*2])
      else $error("new request inside the two sub-phases");
   lines_release_a: assert property (
      !addr_strobe_valid_n |-> ##2 (&addr_n && &req_type_n && &req_parity_n))
      else $error("lines not released after second sub-phase");
   idle_lines_a: assert property (
      addr_strobe_valid_n && $past(addr_strobe_valid_n) && $past(addr_strobe_valid_n, 2)
      |-> &addr_n && &req_parity_n)
      else $error("lines driven while no request");
   reset_idle_a: assert property (disable iff (1'b0)
      $rose(rst_b_i) |-> addr_strobe_valid_n && &addr_n)
      else $error("lines active during reset");
   // Main traffic seen
   cover property (!addr_strobe_valid_n);
   cover property (!addr_strobe_valid_n ##[3:20] !addr_strobe_valid_n);
   cover property (!addr_strobe_valid_n && !addr_n[17]);
endmodule

// ===== tb_top.sv
// Testbench: issuer and agent across the link, plus a fault-injecting second link
`timescale 1ns/1ns
module tb_top;
   logic        ref_clk_i = 1'b0;
   logic        bus_clk = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        req_valid_i = 1'b0;
   logic        mask_i = 1'b0;
   logic        real_mode_i = 1'b0;
   logic [39:0] req_addr_i = 40'h0;
   logic [4:0]  req_type_i = 5'h0;
   logic [36:0] req_info_i = 37'h0;
   logic [39:0] core_addr_i = 40'h0;
   logic        req_ready_o, req_new_o, parity_err_o, new2, err2;
   logic [39:0] core_addr_o, req_addr_o;
   logic [36:0] req_info_o;
   logic [4:0]  req_type_o;
   logic [7:0]  cfg_o;
   int          n_mismatch = 0;
   int          compares = 0;
   int          seed = 52;
   int          cycles = 0;
   int          n_new = 0;
   int          n_new2 = 0;
   int          n_err = 0;
   int          n_perr = 0;
   // Reference clock and unrelated link clock
   always #50 ref_clk_i = ~ref_clk_i;
   initial #13 forever #40 bus_clk = ~bus_clk;
   fsbrq_if bus_if ();
   fsbrq_if bad_if ();
   assign bad_if.bus_clock_true = bus_clk;
   assign bad_if.bus_clock_comp = ~bus_clk;
   fsbrq_issuer #(.DIV(4)) i_fsbrq_issuer (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
      .clk_en_i(1'b1), .req_valid_i(req_valid_i), .req_addr_i(req_addr_i),
      .req_type_i(req_type_i), .req_info_i(req_info_i), .mask_i(mask_i),
      .req_ready_o(req_ready_o), .bus(bus_if));
   fsbrq_agent i_fsbrq_agent (.rst_b_i(rst_b_i), .clk_en_i(1'b1), .real_mode_i(real_mode_i),
      .core_addr_i(core_addr_i), .core_addr_o(core_addr_o), .req_new_o(req_new_o),
      .req_addr_o(req_addr_o), .req_info_o(req_info_o), .req_type_o(req_type_o),
      .parity_err_o(parity_err_o), .cfg_o(cfg_o), .bus(bus_if));
   fsbrq_agent i_fsbrq_agent_2 (.rst_b_i(rst_b_i), .clk_en_i(1'b1), .real_mode_i(real_mode_i),
      .core_addr_i(core_addr_i), .core_addr_o(), .req_new_o(new2), .req_addr_o(),
      .req_info_o(), .req_type_o(), .parity_err_o(err2), .cfg_o(), .bus(bad_if));
   fsbrq_checker i_fsbrq_checker (.bus_clock_true(bus_if.bus_clock_true), .rst_b_i(rst_b_i),
      .addr_n(bus_if.addr_n), .req_type_n(bus_if.req_type_n),
      .addr_strobe_valid_n(bus_if.addr_strobe_valid_n), .req_parity_n(bus_if.req_parity_n));
   // Count agent pulses on the settled half of the link clock
   always @(negedge bus_if.bus_clock_true) begin
      if (req_new_o === 1'b1 && parity_err_o !== 1'b0) n_perr++;
      if (req_new_o === 1'b1) n_new++;
   end
   always @(negedge bus_clk) begin
      if (new2 === 1'b1) n_new2++;
      if (new2 === 1'b1 && err2 === 1'b1) n_err++;
   end
   // Hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   function automatic logic pw(input logic [41:0] v);
      return ~^(~v);
   endfunction
   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic finish_test();
      $display("Compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One request through the issuer, checked at the agent
   task automatic send(input logic [39:0] a, input logic [4:0] t, input logic [36:0] inf);
      int base;
      int k;
      base = n_new;
      @(negedge ref_clk_i);
      req_addr_i = a;
      req_type_i = t;
      req_info_i = inf;
      req_valid_i = 1'b1;
      for (k = 0; k < 50 && req_ready_o !== 1'b1; k++) @(negedge ref_clk_i);
      @(negedge ref_clk_i);
      req_valid_i = 1'b0;
      for (k = 0; k < 50 && n_new == base; k++) @(negedge ref_clk_i);
      check("req_addr", {a[39:3], 3'h0}, req_addr_o);
      check("req_type", {35'h0, t}, {35'h0, req_type_o});
      check("req_info", {3'h0, inf}, {3'h0, req_info_o});
   endtask
   task automatic bad_idle();
      bad_if.addr_n = 37'h1f_ffff_ffff;
      bad_if.req_type_n = 5'h1f;
      bad_if.req_parity_n = 2'h3;
      bad_if.addr_strobe_valid_n = 1'b1;
      bad_if.src_sync_req_strobe_n = 2'h3;
      bad_if.addr_bit20_mask_n = 1'b1;
   endtask
   // Driven request on the second link, with chosen parity lanes flipped
   task automatic bad_req(input logic [1:0] flip);
      logic [36:0] w;
      logic [4:0]  tw;
      logic        hi;
      logic        lo;
      int          b;
      int          e;
      w = 37'({$random(seed), $random(seed)});
      tw = 5'($random(seed));
      hi = pw({26'h3ff_ffff, w[36:21]});
      lo = pw({16'hffff, w[20:0], tw});
      @(posedge bus_clk);
      b = n_new2;
      e = n_err;
      @(negedge bus_clk);
      bad_if.addr_n = w;
      bad_if.req_type_n = tw;
      bad_if.req_parity_n = {lo, hi} ^ flip;
      bad_if.addr_strobe_valid_n = 1'b0;
      @(posedge bus_clk);
      bad_if.src_sync_req_strobe_n <= 2'h0;
      @(negedge bus_clk);
      bad_if.req_parity_n = {hi, lo};
      bad_if.addr_strobe_valid_n = 1'b1;
      @(posedge bus_clk);
      bad_if.src_sync_req_strobe_n <= 2'h3;
      @(negedge bus_clk);
      bad_idle();
      repeat (4) @(posedge bus_clk);
      check("flt req_new", 40'h1, 40'(n_new2 - b));
      check("flt parity_err", {39'h0, flip != 2'h0}, 40'(n_err - e));
   endtask
   // Bit 20 mask against real mode on the core address path
   task automatic mask_case(input logic m, input logic rm);
      logic [39:0] a;
      a = {$random(seed), 8'h00} | 40'h10_0000;
      @(negedge ref_clk_i);
      mask_i = m;
      core_addr_i = a;
      real_mode_i = rm;
      repeat (20) @(negedge ref_clk_i);
      check("core_addr", (m & rm) ? (a & ~40'h10_0000) : a, core_addr_o);
   endtask
   initial begin
      logic [63:0] r;
      bad_idle();
      repeat (3) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      check("cfg", 40'h0, {32'h0, cfg_o});
      send(40'h0, 5'h0, 37'h0);
      send(40'hff_ffff_fff8, 5'h1f, 37'h1f_ffff_ffff);
      for (int i = 0; i < 24; i++) begin
         r = {$random(seed), $random(seed)};
         send(r[39:0], r[44:40], {r[63:40], r[12:0]});
      end
      for (int i = 0; i < 3; i++) bad_req(i[1:0]);
      for (int i = 0; i < 4; i++) mask_case(i[1], i[0]);
      check("good parity errors", 40'h0, 40'(n_perr));
      finish_test();
   end
endmodule
